/* core/meter_pkg.sv */
package meter_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_DISPLAY = 5'h08;
  localparam logic [4:0] REG_IRQ_STATUS = 5'h0c;
  localparam logic [4:0] REG_IRQ_MASK = 5'h10;

  // Control register fields
  localparam int CTRL_SOFT_FREEZE = 0;
  localparam int CTRL_SCAN_EN = 1;

  // Status register fields
  localparam int STAT_OVER = 0;
  localparam int STAT_UNDER = 1;
  localparam int STAT_SIGN = 2;
  localparam int STAT_GT = 3;
  localparam int STAT_FREQ = 4;
  localparam int STAT_FROZEN = 5;

  // Interrupt status and mask fields
  localparam int IRQ_NEW_READING = 0;
  localparam int IRQ_GT_RISE = 1;
  localparam int IRQ_OVER = 2;

  // Reset values of software-visible control
  localparam logic RESET_SOFT_FREEZE = 1'b0;
  localparam logic RESET_SCAN_EN = 1'b1;
  localparam logic [2:0] RESET_IRQ_MASK = 3'h0;

  // Default oscillator divider: mclk cycles per converter clock pulse
  localparam int CLK_DIV_DEFAULT = 4;

  // Converter clock pulses the greater-than flag stands after end of conversion
  localparam int GT_HOLD_PULSES = 50;

  // Under-range threshold as a BCD reading
  localparam logic [15:0] UNDER_RANGE_LIMIT = 16'h0380;

  // Decimal point select codes
  localparam logic [1:0] POINT_ONE = 2'h1;
  localparam logic [1:0] POINT_TWO = 2'h2;
  localparam logic [1:0] POINT_THREE = 2'h3;

  // Digit drive codes, all-off then one-hot, least significant digit first
  localparam logic [3:0] DIGIT_NONE = 4'h0;
  localparam logic [3:0] DIGIT_ONE = 4'h1;
  localparam logic [3:0] DIGIT_TWO = 4'h2;
  localparam logic [3:0] DIGIT_THREE = 4'h4;
  localparam logic [3:0] DIGIT_FOUR = 4'h8;

  // Whole state of the output and scan block
  typedef struct packed {
    logic [7:0] div_cnt;
    logic [3:0] digit;
    logic [15:0] disp;
    logic sign;
    logic over;
    logic under;
    logic gt;
    logic gt_count_on;
    logic [5:0] gt_cnt;
    logic stb_pend;
    logic stb_on;
    logic stb_n;
    logic [3:0] bcd;
    logic sp;
    logic freq;
    logic hold_az;
    logic hold_idle;
    logic soft_freeze;
    logic scan_en;
    logic [2:0] irq_sts;
    logic [2:0] irq_mask;
    logic irq;
    logic ack;
    logic [31:0] rdata;
  } scan_state_t;

endpackage

/* core/meter_result_output_scan.sv */
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/100ps

// Contract
// - Over-range high when input exceeds full scale
// - Voltage mode: sign high for positive input
// - Counter mode: sign always held high
// - Digit as BCD, weight eight is MSB
// - Greater-than rises at integrator zero crossing
// - Greater-than falls 50 pulses after conversion done
// - Four digit drives, first least significant
// - Shared pin: sign on four, points otherwise
// - Under-range high when reading at most 380
// - Select low voltage, high frequency counting
// - Freeze low holds display, converter parks
// - Strobe low half pulse, centred, once per conversion
module meter_result_output_scan #(
  parameter int CLK_DIV = meter_pkg::CLK_DIV_DEFAULT
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic irq,
  // Mode and freeze pins
  input wire logic measurement_select,
  input wire logic freeze_n,
  input wire logic [1:0] point_code,
  // Conversion engine results
  input wire logic conversion_done,
  input wire logic zero_cross,
  input wire logic [15:0] new_bcd,
  input wire logic new_positive,
  input wire logic new_overrange,
  // Conversion engine control
  output logic freq_mode,
  output logic hold_autozero,
  output logic hold_idle,
  // Status pins
  output logic over_range_flag,
  output logic under_range_flag,
  output logic sign_flag,
  output logic new_reading_larger,
  // Multiplexed digit outputs
  output logic bcd_weight_eight,
  output logic bcd_weight_four,
  output logic bcd_weight_two,
  output logic bcd_weight_one,
  output logic digit_select_one,
  output logic digit_select_two,
  output logic digit_select_three,
  output logic digit_select_four,
  output logic sign_point_shared,
  output logic digit_sample_strobe_n
);

  // Strobe window inside one digit pulse: middle half of the converter clock period
  localparam logic [7:0] STB_START = 8'(CLK_DIV / 4);
  localparam logic [7:0] STB_END = 8'(CLK_DIV / 4 + CLK_DIV / 2);
  localparam logic [7:0] DIV_LAST = 8'(CLK_DIV - 1);
  localparam logic [5:0] GT_LAST = 6'(meter_pkg::GT_HOLD_PULSES - 1);

  localparam meter_pkg::scan_state_t STATE_RESET = '{
    div_cnt: 8'h00, digit: meter_pkg::DIGIT_NONE, disp: 16'h0000,
    sign: 1'b0, over: 1'b0, under: 1'b1, gt: 1'b0, gt_count_on: 1'b0,
    gt_cnt: 6'h00, stb_pend: 1'b0, stb_on: 1'b0, stb_n: 1'b1, bcd: 4'h0,
    sp: 1'b0, freq: 1'b0, hold_az: 1'b0, hold_idle: 1'b0,
    soft_freeze: meter_pkg::RESET_SOFT_FREEZE, scan_en: meter_pkg::RESET_SCAN_EN,
    irq_sts: 3'h0, irq_mask: meter_pkg::RESET_IRQ_MASK, irq: 1'b0,
    ack: 1'b0, rdata: 32'h0000_0000
  };

  meter_pkg::scan_state_t st_r;
  meter_pkg::scan_state_t st_nxt;
  logic frozen;
  logic tick;
  logic latch;
  logic req;
  logic [2:0] events;
  logic [2:0] w1c;

  // Freeze comes from the pin or from software; either parks the converter
  assign frozen = ~freeze_n | st_r.soft_freeze;
  // One converter clock pulse every CLK_DIV mclk cycles
  assign tick = (st_r.div_cnt == DIV_LAST);
  // A result is only accepted while not frozen
  assign latch = conversion_done & ~frozen;
  assign req = read | write;

  // Next-state logic for the whole block
  always_comb begin
    st_nxt = st_r;
    events = 3'h0;
    w1c = 3'h0;

    // Oscillator divider
    st_nxt.div_cnt = tick ? 8'h00 : st_r.div_cnt + 8'h01;

    // Mode follows the select pin; frozen converter parks per mode
    st_nxt.freq = measurement_select;
    st_nxt.hold_az = frozen & ~measurement_select;
    st_nxt.hold_idle = frozen & measurement_select;

    // Result latch at end of conversion
    if (latch) begin
      st_nxt.disp = new_bcd;
      st_nxt.over = new_overrange;
      st_nxt.under = (new_bcd <= meter_pkg::UNDER_RANGE_LIMIT);
      st_nxt.sign = new_positive;
      st_nxt.stb_pend = 1'b1;
      events[meter_pkg::IRQ_NEW_READING] = 1'b1;
      events[meter_pkg::IRQ_OVER] = new_overrange;
    end
    // Counter mode has no polarity; sign pinned high
    if (measurement_select) begin
      st_nxt.sign = 1'b1;
    end

    // Greater-than: raised at zero crossing, timed out after end of conversion
    if (zero_cross && !frozen && (new_bcd > st_r.disp)) begin
      st_nxt.gt = 1'b1;
      st_nxt.gt_count_on = 1'b0;
      st_nxt.gt_cnt = 6'h00;
    end else if (st_r.gt && conversion_done) begin
      st_nxt.gt_count_on = 1'b1;
      st_nxt.gt_cnt = 6'h00;
    end else if (st_r.gt_count_on && tick) begin
      if (st_r.gt_cnt == GT_LAST) begin
        st_nxt.gt = 1'b0;
        st_nxt.gt_count_on = 1'b0;
      end else begin
        st_nxt.gt_cnt = st_r.gt_cnt + 6'h01;
      end
    end
    events[meter_pkg::IRQ_GT_RISE] = st_nxt.gt & ~st_r.gt;

    // Digit scan: one drive at a time, advancing each converter clock pulse
    if (!st_r.scan_en) begin
      st_nxt.digit = meter_pkg::DIGIT_NONE;
      st_nxt.stb_on = 1'b0;
    end else if (tick) begin
      if (st_r.digit == meter_pkg::DIGIT_NONE || st_r.digit == meter_pkg::DIGIT_FOUR) begin
        st_nxt.digit = meter_pkg::DIGIT_ONE;
      end else begin
        st_nxt.digit = {st_r.digit[2:0], 1'b0};
      end
      // Strobe goes with the next most significant digit after a new result
      st_nxt.stb_on = st_nxt.stb_pend && (st_nxt.digit == meter_pkg::DIGIT_FOUR);
      if (st_nxt.stb_on) begin
        st_nxt.stb_pend = 1'b0;
      end
    end

    // BCD lines and shared pin follow the digit being driven
    case (st_nxt.digit)
      meter_pkg::DIGIT_ONE: begin
        st_nxt.bcd = st_nxt.disp[3:0];
        st_nxt.sp = (point_code == meter_pkg::POINT_ONE);
      end
      meter_pkg::DIGIT_TWO: begin
        st_nxt.bcd = st_nxt.disp[7:4];
        st_nxt.sp = (point_code == meter_pkg::POINT_TWO);
      end
      meter_pkg::DIGIT_THREE: begin
        st_nxt.bcd = st_nxt.disp[11:8];
        st_nxt.sp = (point_code == meter_pkg::POINT_THREE);
      end
      meter_pkg::DIGIT_FOUR: begin
        st_nxt.bcd = st_nxt.disp[15:12];
        st_nxt.sp = st_nxt.sign;
      end
      default: begin
        st_nxt.bcd = 4'h0;
        st_nxt.sp = 1'b0;
      end
    endcase

    // Strobe low only in the middle half of the chosen digit pulse
    st_nxt.stb_n = ~(st_nxt.stb_on && st_nxt.div_cnt >= STB_START && st_nxt.div_cnt < STB_END);

    // Bus: one wait cycle, read data captured while waiting
    st_nxt.ack = req & ~st_r.ack;
    if (read && !st_r.ack) begin
      case (address)
        meter_pkg::REG_CTRL: begin
          st_nxt.rdata = 32'h0;
          st_nxt.rdata[meter_pkg::CTRL_SOFT_FREEZE] = st_r.soft_freeze;
          st_nxt.rdata[meter_pkg::CTRL_SCAN_EN] = st_r.scan_en;
        end
        meter_pkg::REG_STATUS: begin
          st_nxt.rdata = 32'h0;
          st_nxt.rdata[meter_pkg::STAT_OVER] = st_r.over;
          st_nxt.rdata[meter_pkg::STAT_UNDER] = st_r.under;
          st_nxt.rdata[meter_pkg::STAT_SIGN] = st_r.sign;
          st_nxt.rdata[meter_pkg::STAT_GT] = st_r.gt;
          st_nxt.rdata[meter_pkg::STAT_FREQ] = st_r.freq;
          st_nxt.rdata[meter_pkg::STAT_FROZEN] = frozen;
        end
        meter_pkg::REG_DISPLAY: st_nxt.rdata = {16'h0000, st_r.disp};
        meter_pkg::REG_IRQ_STATUS: st_nxt.rdata = {29'h0, st_r.irq_sts};
        meter_pkg::REG_IRQ_MASK: st_nxt.rdata = {29'h0, st_r.irq_mask};
        default: st_nxt.rdata = 32'h0;
      endcase
    end
    // Writes land on the edge where waitrequest is low; only lane 0 is populated
    if (write && st_r.ack && byteenable[0]) begin
      case (address)
        meter_pkg::REG_CTRL: begin
          st_nxt.soft_freeze = writedata[meter_pkg::CTRL_SOFT_FREEZE];
          st_nxt.scan_en = writedata[meter_pkg::CTRL_SCAN_EN];
        end
        meter_pkg::REG_IRQ_STATUS: w1c = writedata[2:0];
        meter_pkg::REG_IRQ_MASK: st_nxt.irq_mask = writedata[2:0];
        default: w1c = 3'h0;
      endcase
    end

    // Sticky events: a set in the clearing cycle wins
    st_nxt.irq_sts = (st_r.irq_sts & ~w1c) | events;
    st_nxt.irq = |(st_nxt.irq_sts & st_nxt.irq_mask);
  end

  // State register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r <= STATE_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register, except waitrequest, which also decodes read and write
  assign readdata = st_r.rdata;
  assign waitrequest = req & ~st_r.ack;
  assign irq = st_r.irq;
  assign freq_mode = st_r.freq;
  assign hold_autozero = st_r.hold_az;
  assign hold_idle = st_r.hold_idle;
  assign over_range_flag = st_r.over;
  assign under_range_flag = st_r.under;
  assign sign_flag = st_r.sign;
  assign new_reading_larger = st_r.gt;
  assign bcd_weight_eight = st_r.bcd[3];
  assign bcd_weight_four = st_r.bcd[2];
  assign bcd_weight_two = st_r.bcd[1];
  assign bcd_weight_one = st_r.bcd[0];
  assign digit_select_one = st_r.digit[0];
  assign digit_select_two = st_r.digit[1];
  assign digit_select_three = st_r.digit[2];
  assign digit_select_four = st_r.digit[3];
  assign sign_point_shared = st_r.sp;
  assign digit_sample_strobe_n = st_r.stb_n;

  // Checks on the driven outputs
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_over_latch: assert property (latch |=> over_range_flag == $past(new_overrange))
    else $error("over-range flag does not match latched result");

  chk_volt_sign: assert property (latch && !measurement_select |=> sign_flag == $past(new_positive))
    else $error("sign flag does not follow input polarity");

  chk_freq_sign: assert property (measurement_select |=> sign_flag)
    else $error("sign flag low in counter mode");

  chk_bcd_digit: assert property (digit_select_one |->
    {bcd_weight_eight, bcd_weight_four, bcd_weight_two, bcd_weight_one} == st_r.disp[3:0])
    else $error("BCD lines do not show least significant digit");

  chk_gt_raise: assert property (zero_cross && !frozen && (new_bcd > st_r.disp) |=> new_reading_larger)
    else $error("greater-than not raised at zero crossing");

  chk_gt_hold: assert property ($fell(new_reading_larger) |->
    $past(st_r.gt_cnt) == GT_LAST && $past(st_r.gt_count_on) && $past(tick))
    else $error("greater-than fell before its hold count");

  chk_digit_order: assert property (digit_select_one && tick && st_r.scan_en |=> digit_select_two)
    else $error("digit scan out of order");

  chk_point_share: assert property (digit_select_four |-> sign_point_shared == sign_flag)
    else $error("shared pin not showing sign during digit four");

  chk_under_range: assert property (latch |=>
    under_range_flag == ($past(new_bcd) <= meter_pkg::UNDER_RANGE_LIMIT))
    else $error("under-range flag wrong for latched reading");

  chk_mode_park: assert property (!freeze_n |=> (hold_autozero != hold_idle) && hold_idle == freq_mode)
    else $error("parked state does not match selected mode");

  chk_freeze_hold: assert property (frozen |=> $stable(st_r.disp))
    else $error("display changed while frozen");

  chk_strobe_centre: assert property ($fell(digit_sample_strobe_n) |->
    digit_select_four && st_r.div_cnt == STB_START ##1 1'b1)
    else $error("strobe not centred in digit four");

  chk_digit_onehot: assert property ($onehot0({digit_select_four, digit_select_three,
    digit_select_two, digit_select_one}))
    else $error("more than one digit drive active");

  // Scan wrap, strobe placement and idle scan
  chk_digit_wrap: assert property (digit_select_four && tick && st_r.scan_en |=>
    digit_select_one)
    else $error("digit scan does not wrap to digit one");

  chk_strobe_digit: assert property (!digit_sample_strobe_n |->
    digit_select_four)
    else $error("strobe low outside digit four");

  chk_scan_off: assert property (!st_r.scan_en |=>
    {digit_select_four, digit_select_three, digit_select_two, digit_select_one} == meter_pkg::DIGIT_NONE)
    else $error("digit drive active while scan disabled");

  // Data and shared pin at both ends of the scan
  chk_bcd_four: assert property (digit_select_four |->
    {bcd_weight_eight, bcd_weight_four, bcd_weight_two, bcd_weight_one} == st_r.disp[15:12])
    else $error("BCD lines do not show most significant digit");

  chk_point_one: assert property (digit_select_one |->
    sign_point_shared == ($past(point_code) == meter_pkg::POINT_ONE))
    else $error("shared pin not showing point select one");

  // Mode pin and the only sources of flag changes
  chk_mode_follow: assert property (measurement_select |=>
    freq_mode)
    else $error("counter mode not reported");

  chk_volt_mode: assert property (!measurement_select |=>
    !freq_mode)
    else $error("voltage mode not reported");

  chk_gt_source: assert property ($rose(new_reading_larger) |->
    $past(zero_cross) && !$past(frozen))
    else $error("greater-than rose without a zero crossing");

  chk_flag_stable: assert property (!latch |=>
    $stable(over_range_flag) && $stable(under_range_flag))
    else $error("range flags changed without a result");

endmodule // meter_result_output_scan

/* tb/display_capture.sv */
`timescale 1ns/100ps
module display_capture (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Scanned digit lines
  input wire logic [3:0] bcd,
  input wire logic [3:0] dsel,
  input wire logic shared,
  input wire logic strobe_n,
  // What the display has latched
  output logic [15:0] shown,
  output logic [3:0] marks,
  output int bad_sel,
  output int stb_lows
);
  // Latch per digit, loaded only while its drive is high
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      shown <= 16'h0000;
      marks <= 4'h0;
      bad_sel <= 0;
      stb_lows <= 0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (dsel == 4'(1 << i)) begin
          shown[i*4 +: 4] <= bcd;
          marks[i] <= shared;
        end
      end
      // Two drives at once would smear digits; strobe only in digit four
      if ($countones(dsel) > 1 || (!strobe_n && dsel != meter_pkg::DIGIT_FOUR)) begin
        bad_sel <= bad_sel + 1;
      end
      if (!strobe_n) begin
        stb_lows <= stb_lows + 1;
      end
    end
  end
endmodule // display_capture

/* tb/tb_meter_result_output_scan.sv */
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module tb_meter_result_output_scan;
  localparam int CD = 4;
  logic mclk, rst, read, write, waitrequest, irq, measurement_select, freeze_n;
  logic conversion_done, zero_cross, new_positive, new_overrange, freq_mode, hold_autozero, hold_idle;
  logic over_range_flag, under_range_flag, sign_flag, new_reading_larger, sign_point_shared;
  logic bcd_weight_eight, bcd_weight_four, bcd_weight_two, bcd_weight_one, digit_sample_strobe_n;
  logic digit_select_one, digit_select_two, digit_select_three, digit_select_four;
  logic [4:0] address;
  logic [3:0] byteenable, marks;
  logic [31:0] writedata, readdata, q;
  logic [1:0] point_code;
  logic [15:0] new_bcd, shown;
  int failures, cmp_count, bad_sel, stb_lows, n, s0;
  typedef struct packed {logic [15:0] v; logic pos; logic ovr; logic ur; logic sg;} row_t;
  row_t rows [5];

  meter_result_output_scan #(.CLK_DIV(CD)) meter_result_output_scan_inst (.mclk, .rst, .address, .read,
    .write, .byteenable, .writedata, .readdata, .waitrequest, .irq, .measurement_select, .freeze_n,
    .point_code, .conversion_done, .zero_cross, .new_bcd, .new_positive, .new_overrange, .freq_mode,
    .hold_autozero, .hold_idle, .over_range_flag, .under_range_flag, .sign_flag, .new_reading_larger,
    .bcd_weight_eight, .bcd_weight_four, .bcd_weight_two, .bcd_weight_one, .digit_select_one,
    .digit_select_two, .digit_select_three, .digit_select_four, .sign_point_shared, .digit_sample_strobe_n);

  display_capture display_capture_inst (.mclk, .rst,
    .bcd({bcd_weight_eight, bcd_weight_four, bcd_weight_two, bcd_weight_one}),
    .dsel({digit_select_four, digit_select_three, digit_select_two, digit_select_one}),
    .shared(sign_point_shared), .strobe_n(digit_sample_strobe_n), .shown, .marks, .bad_sel, .stb_lows);

  initial mclk = 1'b0;
  always #4 mclk = ~mclk;

  // One Avalon cycle; waitrequest and readdata are looked at settled, just before the deciding edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
    logic w;
    int k;
    k = 0;
    address <= a;
    writedata <= d;
    read <= ~wr;
    write <= wr;
    do begin
      @(negedge mclk);
      w = waitrequest;
      r = readdata;
      @(posedge mclk);
      k++;
    end while (w !== 1'b0 && k < 50);
    if (k >= 50) failures++;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0, r);
  endtask

  // Engine result pulse, then let the flags settle
  task automatic conv(input logic [15:0] v, input logic pos, input logic ovr);
    new_bcd <= v;
    new_positive <= pos;
    new_overrange <= ovr;
    conversion_done <= 1'b1;
    @(posedge mclk);
    conversion_done <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  task automatic zc_pulse(input logic [15:0] v);
    new_bcd <= v;
    zero_cross <= 1'b1;
    @(posedge mclk);
    zero_cross <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Whole run is under a thousand cycles
  initial begin
    repeat (8000) @(posedge mclk);
    failures++;
    wrap_up;
  end

  initial begin
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 5'h00;
    byteenable = 4'hf;
    writedata = 32'h0;
    measurement_select = 1'b0;
    freeze_n = 1'b1;
    point_code = 2'h0;
    conversion_done = 1'b0;
    zero_cross = 1'b0;
    new_bcd = 16'h0000;
    new_positive = 1'b0;
    new_overrange = 1'b0;
    rows = '{'{16'h0380, 1'b1, 1'b0, 1'b1, 1'b1}, '{16'h0381, 1'b0, 1'b0, 1'b0, 1'b0},
             '{16'h1999, 1'b1, 1'b1, 1'b0, 1'b1}, '{16'h0000, 1'b0, 1'b0, 1'b1, 1'b0},
             '{16'h0379, 1'b1, 1'b0, 1'b1, 1'b1}};
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    `CHK(under_range_flag, 1'b1)
    `CHK(irq, 1'b0)
    rd(meter_pkg::REG_CTRL, q);
    `CHK(q, 32'h0000_0002)
    rd(5'h14, q);
    `CHK(q, 32'h0000_0000)
    $display("reset test done");
    // Table of results in voltage mode
    foreach (rows[i]) begin
      s0 = stb_lows;
      conv(rows[i].v, rows[i].pos, rows[i].ovr);
      `CHK(over_range_flag, rows[i].ovr)
      `CHK(under_range_flag, rows[i].ur)
      `CHK(sign_flag, rows[i].sg)
      repeat (6 * CD) @(posedge mclk);
      `CHK(shown, rows[i].v)
      `CHK(marks[3], rows[i].sg)
      `CHK(stb_lows - s0, 2)
    end
    $display("result table done");
    for (int p = 0; p < 4; p++) begin
      point_code <= p[1:0];
      repeat (6 * CD) @(posedge mclk);
      `CHK(marks[2:0], (p == 0) ? 3'h0 : 3'h1 << (p - 1))
    end
    $display("point test done");
    measurement_select <= 1'b1;
    conv(16'h0123, 1'b0, 1'b0);
    `CHK(sign_flag, 1'b1)
    `CHK(freq_mode, 1'b1)
    freeze_n <= 1'b0;
    repeat (2) @(posedge mclk);
    `CHK(hold_idle, 1'b1)
    measurement_select <= 1'b0;
    repeat (2) @(posedge mclk);
    `CHK(hold_autozero, 1'b1)
    conv(16'h0777, 1'b1, 1'b1);
    `CHK(over_range_flag, 1'b0)
    rd(meter_pkg::REG_DISPLAY, q);
    `CHK(q, 32'h0000_0123)
    freeze_n <= 1'b1;
    $display("mode and freeze test done");
    // Greater-than against displayed 0123
    zc_pulse(16'h0100);
    `CHK(new_reading_larger, 1'b0)
    zc_pulse(16'h0456);
    `CHK(new_reading_larger, 1'b1)
    repeat (300) @(posedge mclk);
    `CHK(new_reading_larger, 1'b1)
    conversion_done <= 1'b1;
    @(posedge mclk);
    conversion_done <= 1'b0;
    n = 0;
    // Looked at mid-cycle, so n counts edges up to and including the first one after the fall
    while (new_reading_larger === 1'b1 && n < 400) begin
      @(negedge mclk);
      n++;
    end
    @(posedge mclk);
    `CHK(n >= 49 * CD + 2 && n <= 50 * CD + 1, 1'b1)
    $display("greater-than test done");
    wr(meter_pkg::REG_IRQ_STATUS, 32'h7);
    conv(16'h0200, 1'b1, 1'b1);
    `CHK(irq, 1'b0)
    rd(meter_pkg::REG_IRQ_STATUS, q);
    `CHK(q[2:0], 3'h5)
    wr(meter_pkg::REG_IRQ_MASK, 32'h1);
    `CHK(irq, 1'b1)
    wr(meter_pkg::REG_IRQ_STATUS, 32'h1);
    `CHK(irq, 1'b0)
    $display("interrupt test done");
    wr(meter_pkg::REG_CTRL, 32'h0);
    repeat (2 * CD) @(posedge mclk);
    `CHK({digit_select_four, digit_select_three, digit_select_two, digit_select_one}, 4'h0)
    wr(meter_pkg::REG_CTRL, 32'h2);
    `CHK(bad_sel, 0)
    $display("scan test done");
    wrap_up;
  end
endmodule // tb_meter_result_output_scan
